// ### cbdr_pkg.sv
// How it works
// - Socket power hold ignores power-off requests while the function sits in D3.
// - Voltage force bit reports 3-V capable when 1, not when 0; resets 1.
// - Device control bit 5 is plain storage, resets to 1.
// - Bus-holder enable bit turns link bus-holder cells on or off; resets 0.
// - Two-bit field picks parallel or serialized interrupt signaling; resets 11.
// - Device control byte at offset 92h, reads 66h after reset.
// - Diagnostic byte at offset 93h, read/write, resets to 21h.
// - ID mask bit makes vendor and device ID read all ones.
// - Diagnostic bit 6 always reads zero.
// - Route bit picks which compat register condition sends status changes to PCI.
// - Delayed-transaction disable bit stops delayed transactions.
// - Retry extend bit lengthens target retry latency from 16 to 64 clocks.
// - Card-side discard select: 2^10 clocks when set, 2^15 when clear.
// - Host-side discard select: 2^10 clocks when set, 2^15 when clear.
// - Async enable bit lets status change interrupts fire asynchronously.
// - Retry-expired flag sets after 2^15 clocks; write 1 clears it.
package cbdr_pkg;
  // Offsets
  localparam logic [7:0] OFS_VENDOR_ID   = 8'h00;
  localparam logic [7:0] OFS_DEVICE_ID   = 8'h02;
  localparam logic [7:0] OFS_RETRY_STAT  = 8'h90;
  localparam logic [7:0] OFS_DEV_CTRL    = 8'h92;
  localparam logic [7:0] OFS_DIAG_CTRL   = 8'h93;
  // Reset values
  localparam logic [7:0] RST_DEV_CTRL    = 8'h66;
  localparam logic [7:0] RST_DIAG_CTRL   = 8'h21;
  // Device control fields
  localparam int DC_PWR_HOLD   = 7;
  localparam int DC_LV_FORCE   = 6;
  localparam int DC_DIAG5      = 5;
  localparam int DC_BUS_HOLD   = 4;
  localparam int DC_IRQ_SEL_HI = 2;
  localparam int DC_IRQ_SEL_LO = 1;
  // Diagnostic fields
  localparam int DG_ID_MASK    = 7;
  localparam int DG_RSVD6      = 6;
  localparam int DG_ROUTE      = 5;
  localparam int DG_DT_OFF     = 4;
  localparam int DG_RETRY_LONG = 3;
  localparam int DG_CARD_DSEL  = 2;
  localparam int DG_HOST_DSEL  = 1;
  localparam int DG_ASYNC_EN   = 0;
  // Retry status field
  localparam int RS_EXPIRED    = 1;
  localparam logic [3:0] ROUTE_ZERO = 4'h0;
  // Timing counts in PCI clocks
  localparam int CW = 16;
  localparam logic [CW-1:0] RETRY_LAT_SHORT = 16'h0010;
  localparam logic [CW-1:0] RETRY_LAT_LONG  = 16'h0040;
  localparam logic [CW-1:0] DISCARD_SHORT   = 16'h0400;
  localparam int DISCARD_LONG_DEF = 32768;
  localparam int RETRY_EXP_DEF    = 32768;
  typedef enum logic [1:0] {
    IRQ_PAR_PCI,
    IRQ_PAR_BOTH,
    IRQ_SER_ISA,
    IRQ_SER_BOTH
  } cbdr_irq_mode_t;
endpackage

// ### cbdr_regs.sv
module cbdr_regs
  import cbdr_pkg::*;
#(
  parameter int           DISCARD_LONG_CLKS = DISCARD_LONG_DEF,
  parameter int           RETRY_EXP_CLKS    = RETRY_EXP_DEF,
  parameter logic [15:0]  VENDOR_ID_VAL     = 16'h1234,
  parameter logic [15:0]  DEVICE_ID_VAL     = 16'h5678
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Configuration access
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  // Socket power
  input  wire logic       in_d3,
  input  wire logic       pwr_on_req,
  input  wire logic       pwr_off_req,
  output logic            socket_power_on,
  // Static settings
  output logic            low_voltage_capable,
  output logic            bus_holder_on,
  output logic            delayed_txn_en,
  // Interrupt signaling
  output logic            par_pci_irq_en,
  output logic            par_isa_irq_en,
  output logic            ser_isa_irq_en,
  output logic            ser_pci_irq_en,
  // Status change routing
  input  wire logic       compat_803_b4,
  input  wire logic [3:0] compat_805_hi,
  input  wire logic       csc_pending,
  output logic            csc_pci_async,
  output logic            csc_pci_sync,
  // Target retry latency
  input  wire logic       tgt_wait,
  output logic            tgt_retry,
  // Delayed-transaction discard timers
  input  wire logic       host_dt_hold,
  input  wire logic       card_dt_hold,
  output logic            host_discard,
  output logic            card_discard,
  // Retry expiry watch
  input  wire logic       master_retried,
  output logic            retry_expired
);

  ////////////////////////////////////////////////////////////////////////
  localparam logic [CW-1:0] DLONG = CW'(DISCARD_LONG_CLKS);
  localparam logic [CW-1:0] RLIM  = CW'(RETRY_EXP_CLKS);

  function automatic logic [CW-1:0] discard_lim(input logic short_sel);
    discard_lim = short_sel ? DISCARD_SHORT : DLONG;
  endfunction

  function automatic logic hit(input logic [CW-1:0] cnt,
                               input logic [CW-1:0] lim);
    hit = (cnt == lim - 16'h0001);
  endfunction

  logic [7:0]    dev_ctrl_ff;
  logic [7:0]    diag_ctrl_ff;
  logic          expired_ff;
  logic          pwr_ff;
  logic [7:0]    rdata_ff;
  logic          csc_sync_ff;
  logic [CW-1:0] lat_cnt_ff;
  logic [CW-1:0] hdis_cnt_ff;
  logic [CW-1:0] cdis_cnt_ff;
  logic [CW-1:0] exp_cnt_ff;
  logic [CW-1:0] lat_lim;
  logic [CW-1:0] hdis_lim;
  logic [CW-1:0] cdis_lim;
  logic          wr_dc;
  logic          wr_dg;
  logic          wr_rs;
  logic          expire_now;
  logic          route_ok;
  logic [7:0]    nxt_rdata;
  cbdr_irq_mode_t irq_mode;

  assign wr_dc = cfg_wr && (cfg_addr == OFS_DEV_CTRL);
  assign wr_dg = cfg_wr && (cfg_addr == OFS_DIAG_CTRL);
  assign wr_rs = cfg_wr && (cfg_addr == OFS_RETRY_STAT);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctrl_ff <= RST_DEV_CTRL;
    end else if (wr_dc) begin
      dev_ctrl_ff <= cfg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      diag_ctrl_ff <= RST_DIAG_CTRL;
    end else if (wr_dg) begin
      diag_ctrl_ff <= cfg_wdata & ~(8'h01 << DG_RSVD6);
    end
  end

  // Hardware set beats software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      expired_ff <= 1'b0;
    end else if (expire_now) begin
      expired_ff <= 1'b1;
    end else if (wr_rs && cfg_wdata[RS_EXPIRED]) begin
      expired_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency
  always_comb begin
    nxt_rdata = 8'h00;
    case (cfg_addr)
      OFS_VENDOR_ID:
        nxt_rdata = diag_ctrl_ff[DG_ID_MASK] ? 8'hff : VENDOR_ID_VAL[7:0];
      OFS_VENDOR_ID + 8'h01:
        nxt_rdata = diag_ctrl_ff[DG_ID_MASK] ? 8'hff : VENDOR_ID_VAL[15:8];
      OFS_DEVICE_ID:
        nxt_rdata = diag_ctrl_ff[DG_ID_MASK] ? 8'hff : DEVICE_ID_VAL[7:0];
      OFS_DEVICE_ID + 8'h01:
        nxt_rdata = diag_ctrl_ff[DG_ID_MASK] ? 8'hff : DEVICE_ID_VAL[15:8];
      OFS_RETRY_STAT:
        nxt_rdata = {6'h00, expired_ff, 1'b0};
      OFS_DEV_CTRL:
        nxt_rdata = dev_ctrl_ff;
      OFS_DIAG_CTRL:
        nxt_rdata = diag_ctrl_ff;
      default:
        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (cfg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Socket power
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= 1'b0;
    end else if (pwr_on_req) begin
      pwr_ff <= 1'b1;
    end else if (pwr_off_req && !(dev_ctrl_ff[DC_PWR_HOLD] && in_d3)) begin
      pwr_ff <= 1'b0;
    end
  end

  assign socket_power_on     = pwr_ff;
  assign low_voltage_capable = dev_ctrl_ff[DC_LV_FORCE];
  assign bus_holder_on       = dev_ctrl_ff[DC_BUS_HOLD];
  assign delayed_txn_en      = !diag_ctrl_ff[DG_DT_OFF];

  ////////////////////////////////////////////////////////////////////////
  // Interrupt signaling mode
  assign irq_mode =
    cbdr_irq_mode_t'(dev_ctrl_ff[DC_IRQ_SEL_HI:DC_IRQ_SEL_LO]);

  always_comb begin
    par_pci_irq_en = 1'b0;
    par_isa_irq_en = 1'b0;
    ser_isa_irq_en = 1'b0;
    ser_pci_irq_en = 1'b0;
    case (irq_mode)
      IRQ_PAR_PCI: begin
        par_pci_irq_en = 1'b1;
      end
      IRQ_PAR_BOTH: begin
        par_pci_irq_en = 1'b1;
        par_isa_irq_en = 1'b1;
      end
      IRQ_SER_ISA: begin
        par_pci_irq_en = 1'b1;
        ser_isa_irq_en = 1'b1;
      end
      IRQ_SER_BOTH: begin
        ser_isa_irq_en = 1'b1;
        ser_pci_irq_en = 1'b1;
      end
      default: begin
        par_pci_irq_en = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Status change routing
  assign route_ok = diag_ctrl_ff[DG_ROUTE] ?
                    (compat_805_hi == ROUTE_ZERO) : compat_803_b4;

  // Async path bypasses the clock; sync path waits one edge
  assign csc_pci_async = route_ok && csc_pending &&
                         diag_ctrl_ff[DG_ASYNC_EN];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csc_sync_ff <= 1'b0;
    end else begin
      csc_sync_ff <= route_ok && csc_pending &&
                     !diag_ctrl_ff[DG_ASYNC_EN];
    end
  end

  assign csc_pci_sync = csc_sync_ff;

  ////////////////////////////////////////////////////////////////////////
  // Timers; each restarts when its condition drops
  assign lat_lim  = diag_ctrl_ff[DG_RETRY_LONG] ?
                    RETRY_LAT_LONG : RETRY_LAT_SHORT;
  assign hdis_lim = discard_lim(diag_ctrl_ff[DG_HOST_DSEL]);
  assign cdis_lim = discard_lim(diag_ctrl_ff[DG_CARD_DSEL]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_ff <= '0;
    end else if (!tgt_wait || hit(lat_cnt_ff, lat_lim)) begin
      lat_cnt_ff <= '0;
    end else begin
      lat_cnt_ff <= lat_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hdis_cnt_ff <= '0;
    end else if (!host_dt_hold || hit(hdis_cnt_ff, hdis_lim)) begin
      hdis_cnt_ff <= '0;
    end else begin
      hdis_cnt_ff <= hdis_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cdis_cnt_ff <= '0;
    end else if (!card_dt_hold || hit(cdis_cnt_ff, cdis_lim)) begin
      cdis_cnt_ff <= '0;
    end else begin
      cdis_cnt_ff <= cdis_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exp_cnt_ff <= '0;
    end else if (!master_retried || expire_now) begin
      exp_cnt_ff <= '0;
    end else begin
      exp_cnt_ff <= exp_cnt_ff + 16'h0001;
    end
  end

  assign tgt_retry     = tgt_wait && hit(lat_cnt_ff, lat_lim);
  assign host_discard  = host_dt_hold && hit(hdis_cnt_ff, hdis_lim);
  assign card_discard  = card_dt_hold && hit(cdis_cnt_ff, cdis_lim);
  assign expire_now    = master_retried && hit(exp_cnt_ff, RLIM);
  assign retry_expired = expired_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Cycles of unbroken target wait since the last retry or diag write
  logic [6:0] chk_run_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chk_run_ff <= 7'h00;
    end else if (!tgt_wait || tgt_retry || wr_dg) begin
      chk_run_ff <= 7'h00;
    end else begin
      chk_run_ff <= chk_run_ff + 7'h01;
    end
  end

  a_pwr_hold_d3: assert property (
    pwr_ff && pwr_off_req && !pwr_on_req && in_d3 &&
    dev_ctrl_ff[DC_PWR_HOLD] |=> pwr_ff)
    else $error("socket powered down while held in D3");

  a_pwr_off_ok: assert property (
    pwr_off_req && !pwr_on_req && !in_d3 |=> !pwr_ff)
    else $error("power-off request ignored outside D3");

  a_ctrl_write: assert property (
    wr_dc |=> dev_ctrl_ff == $past(cfg_wdata) &&
              low_voltage_capable == $past(cfg_wdata[DC_LV_FORCE]) &&
              bus_holder_on == $past(cfg_wdata[DC_BUS_HOLD]))
    else $error("device control write not applied");

  a_diag_bit6: assert property (
    cfg_rd && cfg_addr == OFS_DIAG_CTRL |=> !cfg_rdata[DG_RSVD6])
    else $error("diagnostic bit 6 read nonzero");

  a_id_mask: assert property (
    cfg_rd && cfg_addr == OFS_VENDOR_ID && diag_ctrl_ff[DG_ID_MASK]
    |=> cfg_rdata == 8'hff)
    else $error("masked vendor id not all ones");

  a_irq_serial: assert property (
    dev_ctrl_ff[2:1] == 2'b11 |-> ser_pci_irq_en && !par_pci_irq_en)
    else $error("serialized mode drives parallel pci");

  a_route_sel: assert property (
    diag_ctrl_ff[DG_ROUTE] && compat_805_hi != ROUTE_ZERO
    |-> !csc_pci_async ##1 !csc_pci_sync)
    else $error("status change routed with 805 nonzero");

  a_retry_short: assert property (
    tgt_wait && !diag_ctrl_ff[DG_RETRY_LONG] && chk_run_ff == 7'h0f
    |-> tgt_retry)
    else $error("short retry latency not 16 clocks");

  a_retry_long: assert property (
    diag_ctrl_ff[DG_RETRY_LONG] && lat_cnt_ff == 16'h0010 |-> !tgt_retry)
    else $error("long retry latency ended at 16");

  a_discard_sel: assert property (
    host_discard |-> hdis_cnt_ff ==
      (diag_ctrl_ff[DG_HOST_DSEL] ? 16'h03ff : DLONG - 16'h0001))
    else $error("host discard timer length wrong");

  a_card_disc: assert property (
    card_discard |-> cdis_cnt_ff ==
      (diag_ctrl_ff[DG_CARD_DSEL] ? 16'h03ff : DLONG - 16'h0001))
    else $error("card discard timer length wrong");

  a_expire_set: assert property (
    expire_now |=> expired_ff ##0 retry_expired)
    else $error("retry expiry lost");

  a_dt_disable: assert property (
    diag_ctrl_ff[DG_DT_OFF] |-> !delayed_txn_en)
    else $error("delayed transactions still enabled");

  c_id_masked: cover property (
    cfg_rd && cfg_addr == OFS_VENDOR_ID && diag_ctrl_ff[DG_ID_MASK]);
  c_hold_block: cover property (
    pwr_ff && pwr_off_req && in_d3 && dev_ctrl_ff[DC_PWR_HOLD]);
  c_long_retry: cover property (
    tgt_retry && diag_ctrl_ff[DG_RETRY_LONG]);
  c_async_csc: cover property (csc_pci_async);

endmodule

// ### cbdr_host.sv
module cbdr_host
  import cbdr_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Config cycles
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic      [7:0] cfg_addr,
  output logic      [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
  end
  // Test bits of the control byte are always sent as zero
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    cfg_wr    <= 1'b1;
    cfg_addr  <= addr;
    cfg_wdata <= (addr == OFS_DEV_CTRL) ? (data & 8'hf6) : data;
    @(posedge clk_sys);
    cfg_wr    <= 1'b0;
    cfg_addr  <= ~addr;
    cfg_wdata <= ~data;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    cfg_rd   <= 1'b1;
    cfg_addr <= addr;
    @(posedge clk_sys);
    cfg_rd   <= 1'b0;
    cfg_addr <= ~addr;
    @(negedge clk_sys);
    data = cfg_rdata;
  endtask
endmodule

// ### cbdr_regs_bench.sv
module cbdr_regs_bench
  import cbdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLONG = 2048;
  localparam int REXP  = 64;
  logic       clk_sys;
  logic       rst_n;
  logic       cfg_wr;
  logic       cfg_rd;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic       in_d3;
  logic       pwr_on_req;
  logic       pwr_off_req;
  logic       socket_power_on;
  logic       low_voltage_capable;
  logic       bus_holder_on;
  logic       delayed_txn_en;
  logic       par_pci_irq_en;
  logic       par_isa_irq_en;
  logic       ser_isa_irq_en;
  logic       ser_pci_irq_en;
  logic       compat_803_b4;
  logic [3:0] compat_805_hi;
  logic       csc_pending;
  logic       csc_pci_async;
  logic       csc_pci_sync;
  logic [3:0] cond;
  logic       tgt_retry;
  logic       host_discard;
  logic       card_discard;
  logic       retry_expired;
  logic [3:0] pulse;
  logic [7:0] outs;
  logic [7:0] irq_tbl [4];
  int         num_errors;
  int         num_checks;
  assign pulse = {retry_expired, card_discard, host_discard, tgt_retry};
  assign outs  = {low_voltage_capable, bus_holder_on, delayed_txn_en,
                  socket_power_on, par_pci_irq_en, par_isa_irq_en,
                  ser_isa_irq_en, ser_pci_irq_en};
  cbdr_regs #(.DISCARD_LONG_CLKS(DLONG), .RETRY_EXP_CLKS(REXP)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .in_d3(in_d3), .pwr_on_req(pwr_on_req), .pwr_off_req(pwr_off_req),
    .socket_power_on(socket_power_on),
    .low_voltage_capable(low_voltage_capable),
    .bus_holder_on(bus_holder_on), .delayed_txn_en(delayed_txn_en),
    .par_pci_irq_en(par_pci_irq_en), .par_isa_irq_en(par_isa_irq_en),
    .ser_isa_irq_en(ser_isa_irq_en), .ser_pci_irq_en(ser_pci_irq_en),
    .compat_803_b4(compat_803_b4), .compat_805_hi(compat_805_hi),
    .csc_pending(csc_pending), .csc_pci_async(csc_pci_async),
    .csc_pci_sync(csc_pci_sync), .tgt_wait(cond[0]),
    .tgt_retry(tgt_retry), .host_dt_hold(cond[1]),
    .card_dt_hold(cond[2]), .host_discard(host_discard),
    .card_discard(card_discard), .master_retried(cond[3]),
    .retry_expired(retry_expired)
  );
  cbdr_host host (
    .clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(addr, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic pwr(input logic on, input logic off, input logic exp);
    @(posedge clk_sys);
    pwr_on_req  <= on;
    pwr_off_req <= off;
    @(posedge clk_sys);
    pwr_on_req  <= 1'b0;
    pwr_off_req <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0, socket_power_on}, {15'h0, exp});
  endtask
  task automatic status_change_route(input logic [7:0] dg, input logic [3:0] hi,
                     input logic b4, input logic [1:0] exp);
    host.wr(OFS_DIAG_CTRL, dg);
    compat_805_hi <= hi;
    compat_803_b4 <= b4;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({14'h0, csc_pci_async, csc_pci_sync}, {14'h0, exp});
  endtask
  // Cycles of continuous condition until the matching pulse
  task automatic timed(input int idx, input int n);
    int k;
    @(posedge clk_sys);
    cond[idx] <= 1'b1;
    k = 0;
    while (k < 5000 && pulse[idx] !== 1'b1) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 5000) begin
      num_errors++;
      tally_and_finish();
    end
    chk(k[15:0], n[15:0]);
    @(posedge clk_sys);
    cond[idx] <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n         = 1'b0;
    in_d3         = 1'b0;
    pwr_on_req    = 1'b0;
    pwr_off_req   = 1'b0;
    compat_803_b4 = 1'b0;
    compat_805_hi = 4'h0;
    csc_pending   = 1'b0;
    cond          = 4'h0;
    num_errors    = 0;
    num_checks    = 0;
    irq_tbl       = '{8'h08, 8'h0c, 8'h0a, 8'h03};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(OFS_DEV_CTRL, RST_DEV_CTRL);
    rchk(OFS_DIAG_CTRL, RST_DIAG_CTRL);
    rchk(OFS_RETRY_STAT, 8'h00);
    chk({8'h00, outs}, 16'h00a3);
    for (int m = 0; m < 4; m++) begin
      host.wr(OFS_DEV_CTRL, 8'h60 | 8'(m << 1));
      @(negedge clk_sys);
      chk({8'h00, outs}, {8'h00, 8'ha0 | irq_tbl[m]});
      rchk(OFS_DEV_CTRL, 8'h60 | 8'(m << 1));
    end
    host.wr(OFS_DEV_CTRL, 8'h96);
    @(negedge clk_sys);
    chk({8'h00, outs}, 16'h0063);
    rchk(OFS_DEV_CTRL, 8'h96);
    in_d3 <= 1'b1;
    pwr(1'b1, 1'b0, 1'b1);
    pwr(1'b0, 1'b1, 1'b1);
    host.wr(OFS_DEV_CTRL, 8'h16);
    pwr(1'b0, 1'b1, 1'b0);
    in_d3 <= 1'b0;
    pwr(1'b1, 1'b0, 1'b1);
    host.wr(OFS_DEV_CTRL, 8'h96);
    pwr(1'b0, 1'b1, 1'b0);
    host.wr(OFS_DIAG_CTRL, 8'hff);
    rchk(OFS_DIAG_CTRL, 8'hbf);
    chk({15'h0, delayed_txn_en}, 16'h0000);
    rchk(OFS_VENDOR_ID, 8'hff);
    rchk(OFS_DEVICE_ID, 8'hff);
    host.wr(OFS_DIAG_CTRL, 8'h00);
    rchk(OFS_DIAG_CTRL, 8'h00);
    rchk(OFS_VENDOR_ID, 8'h34);
    rchk(OFS_DEVICE_ID, 8'h78);
    rchk(8'h50, 8'h00);
    csc_pending <= 1'b1;
    status_change_route(8'h21, 4'h0, 1'b0, 2'b10);
    status_change_route(8'h21, 4'h1, 1'b1, 2'b00);
    status_change_route(8'h01, 4'h0, 1'b0, 2'b00);
    status_change_route(8'h01, 4'h1, 1'b1, 2'b10);
    status_change_route(8'h00, 4'h1, 1'b1, 2'b01);
    host.wr(OFS_DIAG_CTRL, 8'h0c);
    timed(0, 64);
    timed(1, DLONG);
    timed(2, 1024);
    host.wr(OFS_DIAG_CTRL, 8'h02);
    timed(0, 16);
    timed(1, 1024);
    timed(2, DLONG);
    timed(3, REXP + 1);
    host.wr(OFS_RETRY_STAT, 8'h00);
    rchk(OFS_RETRY_STAT, 8'h02);
    host.wr(OFS_RETRY_STAT, 8'h02);
    rchk(OFS_RETRY_STAT, 8'h00);
    tally_and_finish();
  end
endmodule
